// File: rtl/amx_regs.svh
// timing counts, frame layout and reset values for the sub-channel multiplexer
`ifndef AMX_REGS_SVH
`define AMX_REGS_SVH

// number of asynchronous sub-channels
`define AMX_NCH 8
// system clock period in ns
`define AMX_CLK_NS 4
// main channel bit time in ns
`define AMX_BIT_NS 40
// main channel bit time in clock cycles
`define AMX_BIT_CYC ((`AMX_BIT_NS) / (`AMX_CLK_NS))
// sample point inside a received bit, in cycles from its start
`define AMX_BIT_MID ((`AMX_BIT_CYC) / 2 - 1)
// frame: sync byte then one data and one handshake slot per channel
`define AMX_SYNC 8'ha5
`define AMX_SYNC_W 8
`define AMX_PAY_W (2 * `AMX_NCH)
`define AMX_FRAME_BITS (`AMX_SYNC_W + `AMX_PAY_W)
// payload reset value: data slots idle at one, handshake slots off
`define AMX_PAY_RST 16'haaaa
// good frames needed for lock, missed frames that drop the link
`define AMX_LOCK_FRAMES 2
`define AMX_LOSS_FRAMES 4
// front-panel switch codes
`define AMX_SW_LOCAL 2'h1
`define AMX_SW_REMOTE 2'h2
// test pulse half period in ms, and in clock cycles
`define AMX_PULSE_HALF_MS 250
`define AMX_PULSE_HALF_CYC ((`AMX_PULSE_HALF_MS) * 1000000 / (`AMX_CLK_NS))

`endif

// File: rtl/amx_pkg.sv
// types shared by the sub-channel multiplexer modules
package amx_pkg;
    // operating mode taken from the front-panel switch
    typedef enum logic [1:0] {
        AMX_NORMAL = 2'b00,
        AMX_LOCAL = 2'b01,
        AMX_REMOTE = 2'b10
    } amx_mode_t;
    // main channel receive framer states
    typedef enum logic [1:0] {
        AMX_HUNT = 2'b00,
        AMX_CHECK = 2'b01,
        AMX_LOCK = 2'b10
    } amx_rx_state_t;
endpackage : amx_pkg

// File: rtl/amx_ch_if.sv
// per sub-channel signals between the multiplexer core and a channel slice
`timescale 1ns/100ps
interface amx_ch_if;
    amx_pkg::amx_mode_t mode; // current test mode
    logic hw_hs; // unit carries hardware handshake
    logic link; // framer locked to the remote unit
    logic pulse; // remote loopback test pulse level
    logic term_txd; // line from the terminal
    logic term_rts; // request from the terminal
    logic rx_d; // data slot from the remote unit
    logic rx_h; // handshake slot from the remote unit
    logic slot_d; // data slot toward the remote unit
    logic slot_h; // handshake slot toward the remote unit
    logic term_rxd; // line toward the terminal
    logic term_cts; // clear toward the terminal
    logic led_td_green; // transmit indicator, low means red
    logic led_rd_green; // receive indicator, low means red
    logic led_rts; // request indicator
    logic led_cts; // clear indicator
    modport core (output mode, hw_hs, link, pulse, term_txd, term_rts, rx_d, rx_h,
        input slot_d, slot_h, term_rxd, term_cts, led_td_green, led_rd_green, led_rts, led_cts);
    modport chan (input mode, hw_hs, link, pulse, term_txd, term_rts, rx_d, rx_h,
        output slot_d, slot_h, term_rxd, term_cts, led_td_green, led_rd_green, led_rts, led_cts);
endinterface : amx_ch_if

// File: rtl/amx_chan.sv
// one sub-channel slice: slot selection, loopback, port drivers and indicators
`timescale 1ns/100ps
module amx_chan (
    input wire logic clk,
    input wire logic rst,
    amx_ch_if.chan ch
);
    logic term_rxd_reg; // line toward the terminal
    logic term_rxd_next;
    logic term_cts_reg; // clear toward the terminal
    logic term_cts_next;
    logic led_td_reg; // transmit indicator
    logic led_rd_reg; // receive indicator
    logic led_rts_reg; // request indicator
    logic led_cts_reg; // clear indicator
    wire is_local = (ch.mode == amx_pkg::AMX_LOCAL);
    wire is_remote = (ch.mode == amx_pkg::AMX_REMOTE);

    // data slot: raw line level, no character decode, so any code passes
    assign ch.slot_d = is_remote ? ch.pulse : (is_local ? 1'b1 : ch.term_txd); // RULE1 RULE14
    // handshake slot sampled every frame beside the data slot
    assign ch.slot_h = ch.hw_hs & ~is_local & ch.term_rts; // RULE2 RULE19

    // line toward the terminal: echo in local loop, else the remote slot
    assign term_rxd_next = is_local ? ch.term_txd : // RULE13
        (ch.link ? ch.rx_d : 1'b1); // RULE3 RULE4 RULE15 RULE16
    // clear toward the terminal; idle when the unit has no handshake
    assign term_cts_next = ~ch.hw_hs ? 1'b0 :
        (is_local ? ch.term_rts : (ch.link & ch.rx_h)); // RULE3

    // port drivers and indicators
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            term_rxd_reg <= 1'b1;
            term_cts_reg <= 1'b0;
            led_td_reg <= 1'b0;
            led_rd_reg <= 1'b0;
            led_rts_reg <= 1'b0;
            led_cts_reg <= 1'b0;
        end
        else
        begin
            term_rxd_reg <= term_rxd_next;
            term_cts_reg <= term_cts_next;
            led_td_reg <= ~ch.term_txd; // RULE6
            led_rd_reg <= ~term_rxd_reg; // RULE6
            led_rts_reg <= ch.hw_hs & ch.term_rts; // RULE7
            led_cts_reg <= term_cts_reg; // RULE8
        end
    end

    assign ch.term_rxd = term_rxd_reg;
    assign ch.term_cts = term_cts_reg;
    assign ch.led_td_green = led_td_reg;
    assign ch.led_rd_green = led_rd_reg;
    assign ch.led_rts = led_rts_reg;
    assign ch.led_cts = led_cts_reg;

    // local echo reaches the receive indicator two cycles later
    property p_local_echo;
        @(posedge clk) disable iff (rst)
        is_local [*2] |=> (led_rd_reg == ~$past(ch.term_txd, 2));
    endproperty
    a_local_echo: assert property (p_local_echo) else $error("local echo lost"); // RULE13

    // normal mode with link: remote slot appears on the port
    property p_pass;
        @(posedge clk) disable iff (rst)
        (ch.mode == amx_pkg::AMX_NORMAL && ch.link) |=> (ch.term_rxd == $past(ch.rx_d));
    endproperty
    a_pass: assert property (p_pass) else $error("remote data not passed"); // RULE1

    // clear indicator follows the port a cycle behind
    property p_cts_led;
        @(posedge clk) disable iff (rst)
        $rose(term_cts_reg) |=> led_cts_reg;
    endproperty
    a_cts_led: assert property (p_cts_led) else $error("clear indicator late"); // RULE8

    // remote loop puts the pulse in the data slot
    property p_pulse_slot;
        @(posedge clk) disable iff (rst)
        is_remote |-> (ch.slot_d == ch.pulse);
    endproperty
    a_pulse_slot: assert property (p_pulse_slot) else $error("pulse not in slot"); // RULE14
endmodule : amx_chan

// File: rtl/amx_top.sv
// sub-channel multiplexer core: framer, deframer, test pulse, mode and indicators
// What this block does
// RULE1 - carry every character unchanged, flow codes included
// RULE2 - sample RTS and CTS into composite stream; code samples only RTS, gated by hw_hs and off in local loop
// RULE3 - extract handshake states, drive far-end port
// RULE4 - local port n maps to remote port n
// RULE5 - independent full duplex channels, no configuration
// RULE6 - data indicators red at one, green zero
// RULE7 - green request indicator while terminal asserts RTS; code lights it only while hw_hs is set
// RULE8 - green clear indicator while own CTS asserted
// RULE9 - link indicator lit while remote unit connected
// RULE10 - local-loop indicator lit in local loopback
// RULE11 - remote-loop indicator lit in remote loopback
// RULE12 - normal, local, remote modes from switch
// RULE13 - local loopback echoes each port to itself
// RULE14 - remote loopback sends low-frequency test pulse
// RULE15 - normal remote presents pulse on all ports
// RULE16 - externally looped remote returns the pulse
// RULE17 - operator loops remote port, both units normal
// RULE18 - both terminals use same software flow control
// RULE19 - fixed frame slots per channel, sampled fast
`timescale 1ns/100ps
`include "amx_regs.svh"
module amx_top #(
    parameter int PULSE_HALF_CYC = `AMX_PULSE_HALF_CYC // test pulse half period
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [1:0] mode_sw,
    input wire logic hw_hs,
    input wire logic [`AMX_NCH-1:0] term_txd,
    input wire logic [`AMX_NCH-1:0] term_rts,
    output logic [`AMX_NCH-1:0] term_rxd,
    output logic [`AMX_NCH-1:0] term_cts,
    output logic main_tx,
    input wire logic main_rx,
    output logic [`AMX_NCH-1:0] led_td_green,
    output logic [`AMX_NCH-1:0] led_rd_green,
    output logic [`AMX_NCH-1:0] led_rts,
    output logic [`AMX_NCH-1:0] led_cts,
    output logic led_link,
    output logic led_local,
    output logic led_remote
);
    localparam int FB = `AMX_FRAME_BITS;
    localparam int BC = `AMX_BIT_CYC;

    // mode and test pulse
    amx_pkg::amx_mode_t mode_reg; // registered switch setting
    amx_pkg::amx_mode_t mode_next;
    logic [31:0] pulse_cnt_reg; // test pulse half period counter
    logic pulse_reg; // test pulse level, idle high
    logic led_local_reg;
    logic led_remote_reg;

    // transmit framer
    logic [3:0] tx_bit_reg; // cycles inside a main channel bit
    logic [4:0] tx_pos_reg; // bit index inside the frame
    logic [FB-1:0] tx_sh_reg; // frame shifter, msb goes out first
    logic [`AMX_PAY_W-1:0] tx_pay; // slots gathered from the channels
    wire tx_tick = (tx_bit_reg == 4'(BC - 1));
    wire tx_load = tx_tick && (tx_pos_reg == 5'(FB - 1));

    // receive deframer
    amx_pkg::amx_rx_state_t rx_state_reg;
    amx_pkg::amx_rx_state_t rx_state_next;
    logic rx_prev_reg; // previous line level for edge realignment
    logic [3:0] rx_bit_reg; // cycles since the last bit boundary
    logic [4:0] rx_pos_reg; // bits of the current frame received
    logic [FB-1:0] rx_sh_reg; // received bit history
    logic [`AMX_PAY_W-1:0] rx_pay_reg; // last good payload
    logic [2:0] rx_miss_reg; // consecutive missed syncs
    logic led_link_reg;

    // mode decode from the switch; unused code falls back to normal
    assign mode_next = (mode_sw == `AMX_SW_LOCAL) ? amx_pkg::AMX_LOCAL :
        ((mode_sw == `AMX_SW_REMOTE) ? amx_pkg::AMX_REMOTE : amx_pkg::AMX_NORMAL); // RULE12

    // mode register and test pulse; pulse restarts from idle on each entry
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            mode_reg <= amx_pkg::AMX_NORMAL;
            pulse_cnt_reg <= 32'h0;
            pulse_reg <= 1'b1;
            led_local_reg <= 1'b0;
            led_remote_reg <= 1'b0;
        end
        else
        begin
            mode_reg <= mode_next; // RULE12
            led_local_reg <= (mode_reg == amx_pkg::AMX_LOCAL); // RULE10
            led_remote_reg <= (mode_reg == amx_pkg::AMX_REMOTE); // RULE11
            if (mode_reg != amx_pkg::AMX_REMOTE)
            begin
                pulse_cnt_reg <= 32'h0;
                pulse_reg <= 1'b1;
            end
            else if (pulse_cnt_reg == 32'(PULSE_HALF_CYC - 1))
            begin
                pulse_cnt_reg <= 32'h0;
                pulse_reg <= ~pulse_reg; // RULE14
            end
            else
            begin
                pulse_cnt_reg <= pulse_cnt_reg + 32'h1;
            end
        end
    end

    // transmit framer: sync byte then fixed slots, reloaded each frame
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tx_bit_reg <= 4'h0;
            tx_pos_reg <= 5'h0;
            tx_sh_reg <= '1;
        end
        else
        begin
            tx_bit_reg <= tx_tick ? 4'h0 : tx_bit_reg + 4'h1;
            if (tx_load)
            begin
                tx_pos_reg <= 5'h0;
                tx_sh_reg <= {`AMX_SYNC, tx_pay}; // RULE19
            end
            else if (tx_tick)
            begin
                tx_pos_reg <= tx_pos_reg + 5'h1;
                tx_sh_reg <= {tx_sh_reg[FB-2:0], 1'b1};
            end
        end
    end
    assign main_tx = tx_sh_reg[FB-1];

    // receive sampling: realign on every edge, sample mid-bit
    wire rx_edge = (main_rx != rx_prev_reg);
    wire rx_sample = ~rx_edge && (rx_bit_reg == 4'(`AMX_BIT_MID));
    wire [FB-1:0] rx_sh_new = {rx_sh_reg[FB-2:0], main_rx};
    wire sync_hit = (rx_sh_new[FB-1 -: `AMX_SYNC_W] == `AMX_SYNC);
    wire frame_done = rx_sample && (rx_pos_reg == 5'(FB - 1));
    wire miss_last = (rx_miss_reg == 3'(`AMX_LOSS_FRAMES - 1));

    // framer state: hunt any bit, confirm one frame later, then hold lock
    always_comb
    begin
        rx_state_next = rx_state_reg;
        case (rx_state_reg)
            amx_pkg::AMX_HUNT:
            begin
                if (rx_sample && sync_hit)
                    rx_state_next = amx_pkg::AMX_CHECK;
            end
            amx_pkg::AMX_CHECK:
            begin
                if (frame_done)
                    rx_state_next = sync_hit ? amx_pkg::AMX_LOCK : amx_pkg::AMX_HUNT;
            end
            amx_pkg::AMX_LOCK:
            begin
                if (frame_done && !sync_hit && miss_last)
                    rx_state_next = amx_pkg::AMX_HUNT;
            end
            default:
            begin
                rx_state_next = amx_pkg::AMX_HUNT;
            end
        endcase
    end

    // deframer registers; payload only taken from a frame with valid sync
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rx_state_reg <= amx_pkg::AMX_HUNT;
            rx_prev_reg <= 1'b1;
            rx_bit_reg <= 4'h0;
            rx_pos_reg <= 5'h0;
            rx_sh_reg <= '1;
            rx_pay_reg <= `AMX_PAY_RST;
            rx_miss_reg <= 3'h0;
            led_link_reg <= 1'b0;
        end
        else
        begin
            rx_state_reg <= rx_state_next;
            rx_prev_reg <= main_rx;
            led_link_reg <= (rx_state_reg == amx_pkg::AMX_LOCK); // RULE9
            rx_bit_reg <= (rx_edge || rx_bit_reg == 4'(BC - 1)) ? 4'h0 : rx_bit_reg + 4'h1;
            if (rx_sample)
            begin
                rx_sh_reg <= rx_sh_new;
                rx_pos_reg <= (frame_done || rx_state_reg == amx_pkg::AMX_HUNT) ? 5'h0
                    : rx_pos_reg + 5'h1;
            end
            if (frame_done && sync_hit && rx_state_reg != amx_pkg::AMX_HUNT)
            begin
                rx_pay_reg <= rx_sh_new[`AMX_PAY_W-1:0]; // RULE3
                rx_miss_reg <= 3'h0;
            end
            else if (frame_done && rx_state_reg == amx_pkg::AMX_LOCK)
            begin
                rx_miss_reg <= miss_last ? 3'h0 : rx_miss_reg + 3'h1;
            end
        end
    end

    // one slice per port; slot pair n carries port n both ways
    for (genvar i = 0; i < `AMX_NCH; i++)
    begin : g_ch
        amx_ch_if u_if();
        assign u_if.mode = mode_reg;
        assign u_if.hw_hs = hw_hs;
        assign u_if.link = (rx_state_reg == amx_pkg::AMX_LOCK);
        assign u_if.pulse = pulse_reg;
        assign u_if.term_txd = term_txd[i];
        assign u_if.term_rts = term_rts[i];
        assign u_if.rx_d = rx_pay_reg[`AMX_PAY_W-1-2*i]; // RULE4
        assign u_if.rx_h = rx_pay_reg[`AMX_PAY_W-2-2*i]; // RULE4
        assign tx_pay[`AMX_PAY_W-1-2*i] = u_if.slot_d; // RULE4 RULE19
        assign tx_pay[`AMX_PAY_W-2-2*i] = u_if.slot_h;
        assign term_rxd[i] = u_if.term_rxd;
        assign term_cts[i] = u_if.term_cts;
        assign led_td_green[i] = u_if.led_td_green;
        assign led_rd_green[i] = u_if.led_rd_green;
        assign led_rts[i] = u_if.led_rts;
        assign led_cts[i] = u_if.led_cts;
        // independent slice per port, no shared rate or format state
        amx_chan u_ch (
            .clk(clk),
            .rst(rst),
            .ch(u_if.chan) // RULE5
        );
    end

    assign led_link = led_link_reg;
    assign led_local = led_local_reg;
    assign led_remote = led_remote_reg;

    // every frame load starts with the sync byte
    property p_sync_out;
        @(posedge clk) disable iff (rst)
        tx_load |=> (tx_sh_reg[FB-1 -: `AMX_SYNC_W] == `AMX_SYNC) && (tx_pos_reg == 5'h0);
    endproperty
    a_sync_out: assert property (p_sync_out) else $error("frame without sync"); // RULE19

    // link indicator follows the framer lock a cycle behind
    property p_link_led;
        @(posedge clk) disable iff (rst)
        (rx_state_reg == amx_pkg::AMX_LOCK) |=> led_link;
    endproperty
    a_link_led: assert property (p_link_led) else $error("link indicator off"); // RULE9

    // switch held two cycles lights the local indicator on the next cycle
    property p_local_led;
        @(posedge clk) disable iff (rst)
        (mode_sw == `AMX_SW_LOCAL) [*2] |=> led_local;
    endproperty
    a_local_led: assert property (p_local_led) else $error("local indicator off"); // RULE10

    // remote indicator only while remote mode held
    property p_remote_led;
        @(posedge clk) disable iff (rst)
        led_remote |-> $past(mode_reg) == amx_pkg::AMX_REMOTE;
    endproperty
    a_remote_led: assert property (p_remote_led) else $error("remote indicator wrong"); // RULE11
endmodule : amx_top

// File: test/amx_remote.sv
// behavioural remote multiplexer standing on the far end of the main channel
`timescale 1ns/100ps
`include "amx_regs.svh"
module amx_remote (
    input wire logic clk,
    input wire logic rst,
    input wire logic cut, // cable broken
    input wire logic [7:0] rem_txd, // remote terminal lines
    input wire logic [7:0] rem_rts, // remote terminal requests
    input wire logic main_tx, // stream from the unit under test
    output logic main_rx, // stream toward the unit under test
    output logic [7:0] rem_rxd, // data slots received
    output logic [7:0] rem_hs // handshake slots received
);
    logic [23:0] frame; // next frame to send
    logic [23:0] tx_sh_reg; // outgoing shifter
    logic [4:0] tx_bit_reg; // bit index in frame
    logic [3:0] tx_cyc_reg; // cycle in bit
    logic [23:0] rx_sh_reg; // last 24 bits seen
    logic [3:0] rx_cyc_reg; // cycle in bit, realigned on edges
    logic [5:0] rx_cnt_reg; // bits since accepted sync
    logic rx_prev_reg; // last line level
    // sync byte, then data and handshake slot of each port in order
    always_comb
    begin
        frame = {`AMX_SYNC, 16'h0};
        for (int i = 0; i < 8; i++)
        begin
            frame[15 - 2 * i] = rem_txd[i];
            frame[14 - 2 * i] = rem_rts[i];
        end
    end
    // frames back to back, msb first, ten cycles a bit
    always @(posedge clk)
    begin
        if (rst)
        begin
            tx_cyc_reg <= 4'h0;
            tx_bit_reg <= 5'h17;
            tx_sh_reg <= 24'hffffff;
        end
        else if (tx_cyc_reg != 4'h9)
            tx_cyc_reg <= tx_cyc_reg + 4'h1;
        else
        begin
            tx_cyc_reg <= 4'h0;
            tx_bit_reg <= (tx_bit_reg == 5'h17) ? 5'h0 : tx_bit_reg + 5'h1;
            tx_sh_reg <= (tx_bit_reg == 5'h17) ? frame : {tx_sh_reg[22:0], 1'b1};
        end
        // a cut pair leaves the receiver at a steady space with no transitions
        main_rx <= cut ? 1'b0 : tx_sh_reg[23];
    end
    // receive: mid-bit sampling, a sync counts exactly 24 bits after the last one, or at any time from 48 bits on
    always @(posedge clk)
    begin
        rx_prev_reg <= main_tx;
        rx_cyc_reg <= (main_tx != rx_prev_reg || rx_cyc_reg == 4'h9) ? 4'h0 : rx_cyc_reg + 4'h1;
        if (rst)
        begin
            rx_cnt_reg <= 6'h3f;
            rem_rxd <= 8'hff;
            rem_hs <= 8'h00;
        end
        else if (rx_cyc_reg == 4'h4)
        begin
            rx_sh_reg <= {rx_sh_reg[22:0], main_tx};
            rx_cnt_reg <= (rx_cnt_reg == 6'h3f) ? 6'h3f : rx_cnt_reg + 6'h1;
        end
        // hunting again after two frames guards against a sync aliased in data
        else if (rx_cyc_reg == 4'h5 && rx_sh_reg[23:16] == `AMX_SYNC
            && (rx_cnt_reg == 6'h18 || rx_cnt_reg >= 6'h30))
        begin
            rx_cnt_reg <= 6'h0;
            for (int i = 0; i < 8; i++)
            begin
                rem_rxd[i] <= rx_sh_reg[15 - 2 * i];
                rem_hs[i] <= rx_sh_reg[14 - 2 * i];
            end
        end
    end
endmodule : amx_remote

// File: test/testbench.sv
// self-checking bench: multiplexer against a behavioural remote unit
`timescale 1ns/100ps
module testbench;
    localparam int FRAME = 240; // cycles per composite frame
    localparam int HALF = 1000; // shortened test pulse half period
    localparam int UBIT = 600; // terminal bit time, over two frames
    logic clk, rst, hw_hs, main_tx, main_rx, cut, ext_loop;
    logic led_link, led_local, led_remote;
    logic [1:0] mode_sw;
    logic [7:0] term_txd, term_rts, term_rxd, term_cts, rem_txd, rem_rts, rem_rxd, rem_hs;
    logic [7:0] led_td_green, led_rd_green, led_rts, led_cts;
    int miscompares, checks;
    amx_top #(.PULSE_HALF_CYC(HALF)) u_amx_top (.clk(clk), .rst(rst), .mode_sw(mode_sw),
        .hw_hs(hw_hs), .term_txd(term_txd), .term_rts(term_rts), .term_rxd(term_rxd),
        .term_cts(term_cts), .main_tx(main_tx), .main_rx(main_rx),
        .led_td_green(led_td_green), .led_rd_green(led_rd_green), .led_rts(led_rts),
        .led_cts(led_cts), .led_link(led_link), .led_local(led_local),
        .led_remote(led_remote));
    amx_remote u_amx_remote (.clk(clk), .rst(rst), .cut(cut), .rem_txd(rem_txd),
        .rem_rts(rem_rts), .main_tx(main_tx), .main_rx(main_rx), .rem_rxd(rem_rxd),
        .rem_hs(rem_hs));
    // clock, 4 ns period
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // plug on the local ports turning each line straight back
    always @(posedge clk)
        if (ext_loop)
            term_txd <= term_rxd;
    // compare and count
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // counts, verdict and end of run
    task automatic test_done;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    // bounded wait for the link indicator
    task automatic wait_link(input logic up);
        int n;
        n = 0;
        while (led_link !== up && n < 3000)
        begin
            @(negedge clk);
            n++;
        end
        check("led_link", {7'h0, led_link}, {7'h0, up});
        if (led_link !== up)
            test_done();
    endtask : wait_link
    // both directions at once, handshake carried or not
    task automatic t_normal(input logic hs, input logic [7:0] d);
        @(posedge clk);
        hw_hs <= hs;
        term_txd <= d;
        term_rts <= 8'h0f;
        rem_txd <= ~d;
        rem_rts <= 8'h33;
        repeat (3 * FRAME) @(posedge clk);
        @(negedge clk);
        check("term_rxd", term_rxd, ~d);
        check("rem_rxd", rem_rxd, d);
        check("term_cts", term_cts, hs ? 8'h33 : 8'h00);
        check("rem_hs", rem_hs, hs ? 8'h0f : 8'h00);
        check("led_td_green", led_td_green, ~d);
        check("led_rd_green", led_rd_green, d);
        check("led_rts", led_rts, hs ? 8'h0f : 8'h00);
        check("led_cts", led_cts, hs ? 8'h33 : 8'h00);
    endtask : t_normal
    // one serial character through port 2, received at the far end
    task automatic t_char(input logic [7:0] c);
        int n;
        logic [7:0] got;
        @(posedge clk);
        term_txd <= 8'hff;
        repeat (3 * FRAME) @(posedge clk);
        fork
            for (int i = 0; i < 10; i++)
            begin
                term_txd[2] <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : c[(i + 7) % 8];
                repeat (UBIT) @(posedge clk);
            end
            begin
                n = 0;
                while (rem_rxd[2] !== 1'b0 && n < 3000)
                begin
                    @(negedge clk);
                    n++;
                end
                if (rem_rxd[2] !== 1'b0)
                begin
                    check("char start", {7'h0, rem_rxd[2]}, 8'h00);
                    test_done();
                end
                repeat (UBIT / 2) @(negedge clk);
                for (int j = 0; j < 8; j++)
                begin
                    repeat (UBIT) @(negedge clk);
                    got[j] = rem_rxd[2];
                end
            end
        join
        check("char", got, c);
    endtask : t_char
    // every switch code and its indicators
    task automatic t_modes;
        for (int m = 0; m < 4; m++)
        begin
            @(posedge clk);
            mode_sw <= m[1:0];
            repeat (3) @(negedge clk);
            check("led_local", {7'h0, led_local}, {7'h0, m == 1});
            check("led_remote", {7'h0, led_remote}, {7'h0, m == 2});
        end
    endtask : t_modes
    // local loop echoes each port, one cycle late
    task automatic t_local;
        @(posedge clk);
        mode_sw <= 2'h1;
        hw_hs <= 1'b1;
        term_txd <= 8'h96;
        term_rts <= 8'h5a;
        repeat (3 * FRAME) @(posedge clk);
        @(negedge clk);
        check("term_rxd", term_rxd, 8'h96);
        check("term_cts", term_cts, 8'h5a);
        check("rem_rxd", rem_rxd, 8'hff);
        @(posedge clk);
        term_txd <= 8'h69;
        @(negedge clk);
        @(negedge clk);
        check("term_rxd", term_rxd, 8'h69);
        @(negedge clk);
        check("led_rd_green", led_rd_green, 8'h96);
    endtask : t_local
    // remote loop: all far-end data slots swing low then high together
    task automatic t_remote;
        int n;
        @(posedge clk);
        mode_sw <= 2'h2;
        for (int k = 0; k < 2; k++)
        begin
            n = 0;
            while (rem_rxd !== {8{k[0]}} && n < 4 * HALF)
            begin
                @(negedge clk);
                n++;
            end
            check("pulse", rem_rxd, {8{k[0]}});
            if (rem_rxd !== {8{k[0]}})
                test_done();
        end
        @(posedge clk);
        mode_sw <= 2'h0;
    endtask : t_remote
    // as the far unit of a line test: pulse shown on all ports and returned
    task automatic t_far;
        @(posedge clk);
        ext_loop <= 1'b1;
        for (int k = 0; k < 2; k++)
        begin
            @(posedge clk);
            rem_txd <= {8{k[0]}};
            repeat (6 * FRAME) @(posedge clk);
            @(negedge clk);
            check("term_rxd", term_rxd, {8{k[0]}});
            check("rem_rxd", rem_rxd, {8{k[0]}});
        end
        @(posedge clk);
        ext_loop <= 1'b0;
    endtask : t_far
    // cable cut: link drops, ports go idle; then relock
    task automatic t_loss;
        @(posedge clk);
        cut <= 1'b1;
        wait_link(1'b0);
        check("term_rxd", term_rxd, 8'hff);
        check("term_cts", term_cts, 8'h00);
        @(posedge clk);
        cut <= 1'b0;
        wait_link(1'b1);
    endtask : t_loss
    // main sequence
    initial
    begin
        rst = 1'b1;
        mode_sw = 2'h0;
        hw_hs = 1'b1;
        term_txd = 8'hff;
        term_rts = 8'h00;
        rem_txd = 8'hff;
        rem_rts = 8'h00;
        cut = 1'b0;
        ext_loop = 1'b0;
        miscompares = 0;
        checks = 0;
        repeat (15) @(posedge clk);
        @(negedge clk);
        check("rst term_rxd", term_rxd, 8'hff);
        check("rst led_link", {7'h0, led_link}, 8'h00);
        @(posedge clk);
        rst <= 1'b0;
        wait_link(1'b1);
        t_normal(1'b1, 8'hc3);
        t_normal(1'b0, 8'h5a);
        t_char(8'h13);
        t_char(8'h11);
        t_modes();
        t_local();
        t_remote();
        t_far();
        t_loss();
        test_done();
    end
endmodule : testbench
